//--- mirq_core.sv
/*
 * Meter interrupt status/enable logic with waveform source and rate select.
 * Assumes: serial interface presents one-cycle rd/wr strobes synchronous to
 * clk_sys_i; event inputs come from same-clock datapath logic; zero-crossing
 * level is also same-clock.
 */
`include "mirq_consts.svh"

module mirq_core #(
    parameter int WAVE_WIDTH = 20                        // waveform sample width
) (
    input wire logic clk_sys_i,                          // master clock
    input wire logic sys_rst_i,                          // async reset, high
    input wire mirq_pkg::mirq_reg_req_type req_i,        // register access
    input wire mirq_pkg::mirq_event_type event_i,        // datapath events
    input wire logic [WAVE_WIDTH-1:0] power_i,           // filtered active power
    input wire logic [WAVE_WIDTH-1:0] ch1_i,             // channel 1 samples
    input wire logic [WAVE_WIDTH-1:0] ch2_i,             // channel 2 samples
    output logic [15:0] rdata_o,                         // read data
    output logic [WAVE_WIDTH-1:0] waveform_o,            // waveform register
    output logic irq_n_o,                                // irq pin level (always 0)
    output logic irq_oe_o,                               // irq pin drive enable
    output logic cal_mode_o,                             // calibration mode
    output logic test_mode_o                             // factory test mode
);
    import mirq_pkg::*;

    // ============================================================
    // state
    logic [7:0] interrupt_status;
    logic [7:0] interrupt_enable;
    logic [15:0] mode;
    logic [15:0] rdata;
    logic [WAVE_WIDTH-1:0] waveform;
    logic irq_oe;
    logic msb_seen;

    // ============================================================
    // next values and decodes
    logic [7:0] next_status;
    logic [7:0] next_enable;
    logic [15:0] next_mode;
    logic [15:0] next_rdata;
    logic [WAVE_WIDTH-1:0] next_waveform;
    logic next_irq_oe;
    logic next_msb_seen;
    logic wave_tick;
    logic [7:0] events;
    logic clear_read;
    logic mode_write;
    logic enable_write;
    mirq_rate_type rate_sel;
    mirq_src_type src_sel;

    // address match, shared by the mode write, enable write and clearing read decodes
    function automatic logic hit(input mirq_reg_req_type r, input logic [4:0] a);
        hit = r.addr == a;
    endfunction

    // read mux; unmapped addresses return zero
    function automatic logic [15:0] read_word(
        input logic [4:0] a,
        input logic [7:0] status,
        input logic [7:0] enable,
        input logic [15:0] mode_word
    );
        read_word = 16'h0000;
        if (a == `MIRQ_ADDR_STATUS || a == `MIRQ_ADDR_STATUS_RC) begin
            read_word = {8'h00, status};
        end else if (a == `MIRQ_ADDR_ENABLE) begin
            read_word = {8'h00, enable};
        end else if (a == `MIRQ_ADDR_MODE) begin
            read_word = mode_word;
        end
    endfunction

    // ============================================================
    // access decodes
    assign mode_write = req_i.wr && hit(req_i, `MIRQ_ADDR_MODE);
    assign enable_write = req_i.wr && hit(req_i, `MIRQ_ADDR_ENABLE);
    assign clear_read = req_i.rd && hit(req_i, `MIRQ_ADDR_STATUS_RC);
    assign rate_sel = mirq_rate_type'(mode[`MIRQ_RATE_HI:`MIRQ_RATE_LO]);
    assign src_sel = mirq_src_type'(mode[`MIRQ_SRC_HI:`MIRQ_SRC_LO]);

    // ============================================================
    // waveform timing
    mirq_wave_timer u_timer (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .rate_i(rate_sel),
        .tick_o(wave_tick)
    );

    // ============================================================
    // event collection into the shared layout; dip, no_zero_x and cal_end share one bit
    always_comb begin
        events = 8'h00;
        events[`MIRQ_BIT_HALF_FULL] = event_i.energy_msb & ~msb_seen;
        events[`MIRQ_BIT_DIP] = event_i.dip | event_i.no_zero_x
            | (mode[`MIRQ_CAL_BIT] & event_i.cal_end);
        events[`MIRQ_BIT_WAVE] = wave_tick;
        events[`MIRQ_BIT_THERMAL] = event_i.thermal_done;
        events[`MIRQ_BIT_OVERFLOW] = event_i.energy_ovf;
        // msb taken as low out of reset, so a high level in the first cycle is an edge
        next_msb_seen = event_i.energy_msb;
    end

    // ============================================================
    // status flags, one slice per bit of the shared layout
    // set wins over a same-cycle clearing read, so no event is lost
    generate
        for (genvar b = 0; b < 8; b++) begin : g_flag
            if (b == `MIRQ_BIT_ZERO_X) begin : g_level
                // level copy: a clearing read cannot hide a live crossing
                assign next_status[b] = event_i.zero_x;
            end else begin : g_sticky
                assign next_status[b] = (interrupt_status[b] & ~clear_read) | events[b];
            end
        end
    endgenerate

    // ============================================================
    // configuration word and enable
    always_comb begin
        next_mode = mode;
        next_enable = interrupt_enable;
        if (mode_write) begin
            next_mode = req_i.wdata;
        end
        if (enable_write) begin
            next_enable = req_i.wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mode <= `MIRQ_RST_MODE;
            interrupt_enable <= `MIRQ_RST_ENABLE;
        end else begin
            mode <= next_mode;
            interrupt_enable <= next_enable;
        end
    end

    // ============================================================
    // read data, held until the next read strobe
    always_comb begin
        next_rdata = rdata;
        if (req_i.rd) begin
            next_rdata = read_word(req_i.addr, interrupt_status, interrupt_enable, mode);
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ============================================================
    // waveform register
    always_comb begin
        next_waveform = waveform;
        if (wave_tick) begin
            unique case (src_sel)
                MIRQ_SRC_POWER: next_waveform = power_i;
                MIRQ_SRC_RESERVED: next_waveform = waveform; // reserved: hold
                MIRQ_SRC_CH1: next_waveform = ch1_i;
                MIRQ_SRC_CH2: next_waveform = ch2_i;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            waveform <= '0;
        end else begin
            waveform <= next_waveform;
        end
    end

    // ============================================================
    // status, interrupt pin and msb edge memory
    always_comb begin
        // built from next values so the pin moves on the same edge as the flag
        next_irq_oe = |(next_status & next_enable);
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            interrupt_status <= `MIRQ_RST_STATUS;
            irq_oe <= 1'b0;
            msb_seen <= 1'b0;
        end else begin
            interrupt_status <= next_status;
            irq_oe <= next_irq_oe;
            msb_seen <= next_msb_seen;
        end
    end

    // ============================================================
    // outputs; open drain: level fixed low, only the enable moves
    assign rdata_o = rdata;
    assign waveform_o = waveform;
    assign irq_n_o = 1'b0;
    assign irq_oe_o = irq_oe;
    assign cal_mode_o = mode[`MIRQ_CAL_BIT];
    assign test_mode_o = mode[`MIRQ_TEST_BIT];
endmodule

//--- mirq_consts.svh
/*
 * Offsets, field positions, reset values and timing counts for the meter
 * interrupt and waveform-select block.
 * Assumes: included by bare name from the design, checker and testbench files.
 */
`ifndef MIRQ_CONSTS_SVH
`define MIRQ_CONSTS_SVH

// ============================================================
// register addresses (5-bit register address space)
`define MIRQ_ADDR_STATUS 5'h04
`define MIRQ_ADDR_STATUS_RC 5'h05
`define MIRQ_ADDR_MODE 5'h06
`define MIRQ_ADDR_ENABLE 5'h0A

// ============================================================
// status bit positions
`define MIRQ_BIT_HALF_FULL 0
`define MIRQ_BIT_DIP 1
`define MIRQ_BIT_WAVE 3
`define MIRQ_BIT_ZERO_X 4
`define MIRQ_BIT_THERMAL 5
`define MIRQ_BIT_OVERFLOW 7

// ============================================================
// configuration word fields
`define MIRQ_CAL_BIT 7
`define MIRQ_RATE_LO 11
`define MIRQ_RATE_HI 12
`define MIRQ_SRC_LO 13
`define MIRQ_SRC_HI 14
`define MIRQ_TEST_BIT 15

// ============================================================
// reset values
`define MIRQ_RST_STATUS 8'h00
`define MIRQ_RST_ENABLE 8'h00
`define MIRQ_RST_MODE 16'h000C

// ============================================================
// waveform update dividers, master clock cycles
`define MIRQ_DIV_128 11'h080
`define MIRQ_DIV_256 11'h100
`define MIRQ_DIV_512 11'h200
`define MIRQ_DIV_1024 11'h400

`endif

//--- mirq_pkg.sv
/*
 * Types shared by the meter interrupt block.
 * Assumes: mirq_consts.svh is on the include path.
 */
package mirq_pkg;
    typedef enum logic [1:0] {
        MIRQ_RATE_128,
        MIRQ_RATE_256,
        MIRQ_RATE_512,
        MIRQ_RATE_1024
    } mirq_rate_type;

    typedef enum logic [1:0] {
        MIRQ_SRC_POWER,
        MIRQ_SRC_RESERVED,
        MIRQ_SRC_CH1,
        MIRQ_SRC_CH2
    } mirq_src_type;

    // event strobes from the metering datapath, one-cycle pulses unless noted
    typedef struct packed {
        logic energy_msb;     // accumulator msb level
        logic energy_ovf;     // accumulator overflow pulse
        logic dip;            // line dip detected pulse
        logic no_zero_x;      // zero crossings stopped pulse
        logic cal_end;        // calibration integration end pulse
        logic zero_x;         // zero-crossing logic level
        logic thermal_done;   // temperature conversion done pulse
    } mirq_event_type;

    // register access strobes from the serial interface
    typedef struct packed {
        logic rd;             // one-cycle read strobe
        logic wr;             // one-cycle write strobe
        logic [4:0] addr;     // register address
        logic [15:0] wdata;   // write data
    } mirq_reg_req_type;
endpackage

//--- mirq_wave_timer.sv
/*
 * Waveform update timer: one-cycle tick every 128/256/512/1024 clocks.
 * Assumes: runs on the master clock; rate may change at any time.
 */
`include "mirq_consts.svh"

module mirq_wave_timer (
    input wire logic clk_sys_i,                 // master clock
    input wire logic sys_rst_i,                 // async reset, high
    input wire mirq_pkg::mirq_rate_type rate_i, // sample rate select
    output logic tick_o                         // waveform update pulse
);
    import mirq_pkg::*;

    logic [10:0] count;
    logic [10:0] next_count;
    logic tick;
    logic next_tick;
    logic [10:0] period;

    // ============================================================
    // divider
    always_comb begin
        unique case (rate_i)
            MIRQ_RATE_128: period = `MIRQ_DIV_128;
            MIRQ_RATE_256: period = `MIRQ_DIV_256;
            MIRQ_RATE_512: period = `MIRQ_DIV_512;
            MIRQ_RATE_1024: period = `MIRQ_DIV_1024;
        endcase
        // >= so a shrinking rate cannot strand the counter above the period
        if (count + 11'h001 >= period) begin
            next_count = 11'h000;
            next_tick = 1'b1;
        end else begin
            next_count = count + 11'h001;
            next_tick = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= 11'h000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign tick_o = tick;
endmodule

//--- mirq_core_properties.sv
/* Checker for the mirq_core ports: irq pin, clearing read, mode bits, read data.
   Assumes: bound to mirq_core; the enable register is mirrored from bus writes. */
`include "mirq_consts.svh"
module mirq_core_properties (
    input wire logic clk_sys_i, // master clock
    input wire logic sys_rst_i, // async reset, high
    input wire mirq_pkg::mirq_reg_req_type req_i, // register access
    input wire mirq_pkg::mirq_event_type event_i, // datapath events
    input wire logic [15:0] rdata_o, // read data
    input wire logic irq_n_o, // irq pin level
    input wire logic irq_oe_o, // irq drive enable
    input wire logic cal_mode_o, // calibration mode
    input wire logic test_mode_o // factory test mode
);
    timeunit 1ns;
    timeprecision 1ns;
    import mirq_pkg::*;
    // ====
    // enable mirror, since the enable is not visible at the ports
    logic [7:0] en;
    logic [7:0] next_en;
    always_comb begin
        next_en = en;
        if (req_i.wr && req_i.addr == `MIRQ_ADDR_ENABLE) next_en = req_i.wdata[7:0];
    end
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) en <= `MIRQ_RST_ENABLE;
        else en <= next_en;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ====
    // properties
    sequence quiet_clear_s;
        req_i.rd && req_i.addr == `MIRQ_ADDR_STATUS_RC && event_i == '0 && !en[3];
    endsequence
    irq_pin_low_a:
        assert property (irq_n_o == 1'b0) else $error("irq pin level not low");
    dip_raises_irq_a:
        assert property (event_i.dip && en[1] |=> irq_oe_o) else $error("dip irq missing");
    ovf_raises_irq_a:
        assert property (event_i.energy_ovf && en[7] |=> irq_oe_o) else $error("ovf irq missing");
    temp_raises_irq_a:
        assert property (event_i.thermal_done && en[5] |=> irq_oe_o) else $error("temp irq missing");
    zero_cross_irq_a:
        assert property (event_i.zero_x && en[4] |=> irq_oe_o) else $error("zx irq missing");
    clear_releases_a:
        assert property (quiet_clear_s |=> !irq_oe_o) else $error("irq held after clear");
    unmapped_zero_a:
        assert property (req_i.rd && req_i.addr == 5'h1F |=> rdata_o == 16'h0000)
            else $error("unmapped read not zero");
    rdata_stands_a:
        assert property (!req_i.rd |=> $stable(rdata_o)) else $error("read data moved");
    mode_write_a:
        assert property (req_i.wr && req_i.addr == `MIRQ_ADDR_MODE |=>
            cal_mode_o == $past(req_i.wdata[7]) && test_mode_o == $past(req_i.wdata[15]))
            else $error("mode bits not taken");
endmodule
bind mirq_core mirq_core_properties chk_i (.clk_sys_i, .sys_rst_i, .req_i, .event_i,
    .rdata_o, .irq_n_o, .irq_oe_o, .cal_mode_o, .test_mode_o);

//--- mirq_host_model.sv
/* Host model: one-cycle register strobes launched at falling edges; irq pull-up.
   Assumes: requests are taken at the rising edge, read data stands until next read. */
module mirq_host_model (
    input wire logic clk_sys_i, // master clock
    input wire logic [15:0] rdata_i, // read data
    input wire logic irq_oe_i, // irq pin pulled low
    output mirq_pkg::mirq_reg_req_type req_o, // register access
    output logic irq_line_o // irq wire level
);
    timeunit 1ns;
    timeprecision 1ns;
    import mirq_pkg::*;
    assign irq_line_o = irq_oe_i ? 1'b0 : 1'b1;
    initial req_o = '{rd: 1'b0, wr: 1'b0, addr: 5'h1F, wdata: 16'hFFFF};
    task automatic xfer(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys_i);
        req_o = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk_sys_i);
        // released lines show a different value, not the last one
        req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        xfer(1'b0, a, 16'h0000);
        @(negedge clk_sys_i);
        d = rdata_i;
    endtask
endmodule

//--- meter_irq_and_waveform_select_tb_top.sv
/* Testbench for mirq_core: register reads and writes, event pulses, waveform timing.
   Assumes: mirq_consts.svh on the include path; checker bound separately. */
`include "mirq_consts.svh"
module meter_irq_and_waveform_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mirq_pkg::*;
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    mirq_reg_req_type req_i;
    mirq_event_type event_i = '0;
    logic [19:0] ch1_i = 20'h00000;
    logic [19:0] waveform_o;
    logic [15:0] rdata_o, rd_data;
    logic irq_n_o, irq_oe_o, irq_line, cal_mode_o, test_mode_o;
    int num_errors = 0, num_checks = 0, gap;
    logic [19:0] held;
    logic [6:0] ev_mask [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h01};
    logic [15:0] ev_bit [6] = '{16'h01, 16'h80, 16'h02, 16'h02, 16'h00, 16'h20};
    logic [1:0] src [3] = '{2'b00, 2'b11, 2'b01};
    logic [19:0] src_val [3] = '{20'h11111, 20'h33333, 20'h33333};
    initial forever #50 clk_sys_i = ~clk_sys_i;
    // ch1 moves every cycle so each waveform load is visible
    always @(negedge clk_sys_i) ch1_i <= ch1_i + 20'h00001;
    mirq_core dut (.clk_sys_i, .sys_rst_i, .req_i, .event_i, .power_i(20'h11111), .ch1_i,
        .ch2_i(20'h33333), .rdata_o, .waveform_o, .irq_n_o, .irq_oe_o, .cal_mode_o,
        .test_mode_o);
    mirq_host_model host (.clk_sys_i, .rdata_i(rdata_o), .irq_oe_i(irq_oe_o), .req_o(req_i),
        .irq_line_o(irq_line));
    // ====
    // tasks
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] m, e, input string n);
        host.rd(a, rd_data);
        chk(n, {4'h0, e}, {4'h0, rd_data & m});
    endtask
    task automatic pulse(input logic [6:0] m);
        @(negedge clk_sys_i);
        event_i = m;
        @(negedge clk_sys_i);
        event_i = '0;
        @(negedge clk_sys_i);
    endtask
    // second change-to-change span; the first may be cut short by the rate write
    task automatic gap_of(output int n);
        logic [19:0] w;
        for (int k = 0; k < 2; k++) begin
            w = waveform_o;
            n = 0;
            while (waveform_o === w && n < 1100) begin
                @(negedge clk_sys_i);
                n++;
            end
        end
        if (n >= 1100) begin
            num_errors++;
            give_verdict();
        end
    endtask
    // ====
    // sequence
    initial begin
        repeat (5) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        rc(`MIRQ_ADDR_STATUS, 16'hFFFF, 16'h0000, "status");
        rc(`MIRQ_ADDR_ENABLE, 16'hFFFF, 16'h0000, "enable");
        rc(`MIRQ_ADDR_MODE, 16'hFFFF, 16'h000C, "mode");
        rc(5'h1F, 16'hFFFF, 16'h0000, "unmapped");
        host.xfer(1'b1, `MIRQ_ADDR_ENABLE, 16'h00A3);
        foreach (ev_mask[i]) begin
            pulse(ev_mask[i]);
            chk("irq line", {19'h0, ev_bit[i] == 16'h0}, {19'h0, irq_line});
            rc(`MIRQ_ADDR_STATUS, 16'h00F7, ev_bit[i], "status");
            rc(`MIRQ_ADDR_STATUS_RC, 16'h00F7, ev_bit[i], "clearing");
            rc(`MIRQ_ADDR_STATUS, 16'h00F7, 16'h0000, "after clear");
            chk("irq line", 20'h00001, {19'h0, irq_line});
        end
        host.xfer(1'b1, `MIRQ_ADDR_ENABLE, 16'h0012);
        event_i.zero_x = 1'b1;
        rc(`MIRQ_ADDR_STATUS_RC, 16'h00F7, 16'h0010, "zero cross");
        rc(`MIRQ_ADDR_STATUS, 16'h00F7, 16'h0010, "zero cross held");
        chk("irq line", 20'h00000, {19'h0, irq_line});
        event_i.zero_x = 1'b0;
        @(negedge clk_sys_i);
        chk("irq line", 20'h00001, {19'h0, irq_line});
        host.xfer(1'b1, `MIRQ_ADDR_MODE, 16'h808C);
        chk("cal mode", 20'h00001, {19'h0, cal_mode_o});
        chk("test mode", 20'h00001, {19'h0, test_mode_o});
        pulse(7'h04);
        rc(`MIRQ_ADDR_STATUS_RC, 16'h00F7, 16'h0002, "cal end");
        // host keeps the factory test bit at zero from here on
        for (int r = 0; r < 4; r++) begin
            host.xfer(1'b1, `MIRQ_ADDR_MODE, {3'b010, r[1:0], 11'h08C});
            gap_of(gap);
            chk("gap", 20'h080 << r, gap[19:0]);
            rc(`MIRQ_ADDR_STATUS_RC, 16'h0008, 16'h0008, "sample flag");
        end
        foreach (src[i]) begin
            host.xfer(1'b1, `MIRQ_ADDR_MODE, {1'b0, src[i], 13'h000C});
            repeat (300) @(negedge clk_sys_i);
            chk("waveform", src_val[i], waveform_o);
        end
        // moving channel 1 data tells a hold apart from any constant source
        host.xfer(1'b1, `MIRQ_ADDR_MODE, 16'h400C);
        repeat (300) @(negedge clk_sys_i);
        chk("ch1 recent", 20'h00001, {19'h0, (ch1_i - waveform_o) < 20'h00082});
        host.xfer(1'b1, `MIRQ_ADDR_MODE, 16'h200C);
        held = waveform_o;
        repeat (300) @(negedge clk_sys_i);
        chk("reserved hold", held, waveform_o);
        give_verdict();
    end
endmodule
